// [ssf_status.sv]
/*
 * Status-flag part of a serial peripheral: receive-full and match flags,
 * receive buffer, match value, interrupt status and mask, APB slave.
 * Assumes the shift engine gives a one-cycle transfer-done strobe with the
 * received byte, both synchronous to pclk.
 */
`timescale 1ns/100ps

// How it works
// (R1) Status writes change nothing but match clear
// (R2) Status bits three to zero read zero
// (R3) Transfer completion sets receive-full bit seven
// (R4) Full clears after status read, data read
// (R5) Match bit six sets when a newly received byte equals match
// (R6) Match clears after read, then write one
// (R7) Match reads zero when buffer differs
// (R8) Reset clears both flags
module ssf_status
	import ssf_pkg::*;
(
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Shift engine side
	input wire logic xfer_done,
	input wire logic [BYTE_W-1:0] rx_data,
	// Interrupt and flags
	output logic irq,
	output ssf_flags_s flags
);

	// Register address decode, used for every register
	function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] idx);
		reg_hit = (a == (idx << IDX_SHIFT));
	endfunction

	ssf_bus_e bus_q; // Handshake state
	logic pready_q; // Answer strobe
	logic pslverr_q; // Unmapped access
	logic [DATA_W-1:0] prdata_q; // Read data held through answer
	ssf_flags_s flags_q; // The two status flags
	logic arm_full_q; // Status read seen with full set
	logic arm_match_q; // Status read seen with match set
	logic [BYTE_W-1:0] rxbuf_q; // Received byte
	logic [BYTE_W-1:0] match_val_q; // Software match value
	logic [EV_W-1:0] ev_q; // Sticky interrupt events
	logic [EV_W-1:0] mask_q; // Interrupt mask
	logic irq_q; // Registered interrupt
	logic match_set_q; // Full just set, compare pending

	logic done; // Access completes this edge
	logic rd_status, rd_data, wr_status; // Completed accesses
	logic wr_match, wr_evst, wr_mask; // Completed writes
	logic mapped; // Address decodes to a register
	logic equal; // Buffer equals match value
	logic [DATA_W-1:0] rdata_d; // Read mux
	logic [EV_W-1:0] ev_set; // Event pulses this cycle

	// Completion happens only with the enable high
	assign done = clk_en && psel && penable && pready_q;
	assign rd_status = done && !pwrite && reg_hit(paddr, IDX_SERIAL_STATUS);
	assign rd_data = done && !pwrite && reg_hit(paddr, IDX_RX_DATA);
	assign wr_status = done && pwrite && reg_hit(paddr, IDX_SERIAL_STATUS);
	assign wr_match = done && pwrite && pstrb[0]
		&& reg_hit(paddr, IDX_MATCH_VALUE);
	assign wr_evst = done && pwrite && pstrb[0]
		&& reg_hit(paddr, IDX_INT_STATUS);
	assign wr_mask = done && pwrite && pstrb[0]
		&& reg_hit(paddr, IDX_INT_MASK);
	assign mapped = reg_hit(paddr, IDX_SERIAL_STATUS)
		|| reg_hit(paddr, IDX_MATCH_VALUE) || reg_hit(paddr, IDX_RX_DATA)
		|| reg_hit(paddr, IDX_INT_STATUS) || reg_hit(paddr, IDX_INT_MASK);
	assign equal = (rxbuf_q == match_val_q);

	// Read mux; status byte built from flags
	always_comb begin
		rdata_d = RDATA_RESET;
		if (reg_hit(paddr, IDX_SERIAL_STATUS)) begin
			rdata_d[BIT_FULL] = flags_q.full; // R3
			rdata_d[BIT_MATCH] = flags_q.match && equal; // R7
			rdata_d[3:0] = STATUS_LOW_ZERO; // R2
		end else if (reg_hit(paddr, IDX_MATCH_VALUE)) begin
			rdata_d[BYTE_W-1:0] = match_val_q;
		end else if (reg_hit(paddr, IDX_RX_DATA)) begin
			rdata_d[BYTE_W-1:0] = rxbuf_q;
		end else if (reg_hit(paddr, IDX_INT_STATUS)) begin
			rdata_d[EV_W-1:0] = ev_q;
		end else if (reg_hit(paddr, IDX_INT_MASK)) begin
			rdata_d[EV_W-1:0] = mask_q;
		end
	end

	// APB handshake: one wait state, so data is taken from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_q <= BUS_IDLE;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= RDATA_RESET;
		end else if (clk_en) begin
			case (bus_q)
				BUS_IDLE: begin
					// Access phase seen: prepare the answer
					if (psel && penable) begin
						bus_q <= BUS_ANSWER;
						pready_q <= 1'b1;
						pslverr_q <= !mapped;
						prdata_q <= pwrite ? RDATA_RESET : rdata_d;
					end
				end
				BUS_ANSWER: begin
					// Answer stands exactly one cycle
					bus_q <= BUS_IDLE;
					pready_q <= 1'b0;
					pslverr_q <= 1'b0;
				end
				default: begin
					bus_q <= BUS_IDLE;
					pready_q <= 1'b0;
				end
			endcase
		end
	end

	// Receive buffer takes the byte at transfer end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxbuf_q <= RXBUF_RESET;
		end else if (clk_en && xfer_done) begin
			rxbuf_q <= rx_data;
		end
	end

	// Match value; software writable byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_val_q <= MATCH_RESET;
		end else if (clk_en && wr_match) begin
			match_val_q <= pwdata[BYTE_W-1:0];
		end
	end

	// Receive-full flag and its read arming; set beats clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_q.full <= 1'b0; // R8
			arm_full_q <= 1'b0;
		end else if (clk_en) begin
			if (xfer_done) begin
				flags_q.full <= 1'b1; // R3
				arm_full_q <= 1'b0;
			end else if (rd_data && arm_full_q) begin
				flags_q.full <= 1'b0; // R4
				arm_full_q <= 1'b0;
			end else if (rd_status && flags_q.full) begin
				arm_full_q <= 1'b1; // R4
			end
		end
	end

	// Compare one cycle after full sets, once the buffer holds the byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_set_q <= 1'b0;
		end else if (clk_en) begin
			match_set_q <= xfer_done;
		end
	end

	// Match flag; a status write touches only this bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_q.match <= 1'b0; // R8
			arm_match_q <= 1'b0;
		end else if (clk_en) begin
			if (match_set_q && equal) begin
				flags_q.match <= 1'b1; // R5
				arm_match_q <= 1'b0;
			end else if (!equal) begin
				// Stale match never shows
				flags_q.match <= 1'b0; // R7
				arm_match_q <= 1'b0;
			end else if (wr_status && arm_match_q && pstrb[0]
				&& pwdata[BIT_MATCH]) begin
				flags_q.match <= 1'b0; // R1 R6
				arm_match_q <= 1'b0;
			end else if (rd_status && flags_q.match) begin
				arm_match_q <= 1'b1; // R6
			end
		end
	end

	assign ev_set[EV_FULL] = xfer_done;
	assign ev_set[EV_MATCH] = match_set_q && equal;

	// Sticky events, write one to clear; a new event wins
	generate
		for (genvar i = 0; i < EV_W; i++) begin : g_ev
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ev_q[i] <= 1'b0;
				end else if (clk_en) begin
					if (ev_set[i]) begin
						ev_q[i] <= 1'b1;
					end else if (wr_evst && pwdata[i]) begin
						ev_q[i] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// Interrupt mask, one enables the event
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= EV_RESET;
		end else if (clk_en && wr_mask) begin
			mask_q <= pwdata[EV_W-1:0];
		end
	end

	// Level interrupt, one cycle behind the sticky bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else if (clk_en) begin
			irq_q <= |(ev_q & mask_q);
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign irq = irq_q;
	assign flags = flags_q;

	// Checks: named steps of the two clear sequences
	sequence s_status_read;
		rd_status;
	endsequence

	sequence s_data_read_armed;
		rd_data && arm_full_q;
	endsequence

	property p_status_write_inert;
		@(posedge pclk) disable iff (!presetn)
		(wr_status && !xfer_done) |=> (flags_q.full == $past(flags_q.full));
	endproperty
	a_status_write_inert: assert property (p_status_write_inert) // R1
		else $error("status write changed full flag");

	property p_low_bits_zero;
		@(posedge pclk) disable iff (!presetn)
		(pready_q && !pwrite && reg_hit(paddr, IDX_SERIAL_STATUS))
		|-> (prdata_q[3:0] == STATUS_LOW_ZERO);
	endproperty
	a_low_bits_zero: assert property (p_low_bits_zero) // R2
		else $error("status low bits not zero");

	property p_full_set;
		@(posedge pclk) disable iff (!presetn)
		(clk_en && xfer_done) |=> flags_q.full;
	endproperty
	a_full_set: assert property (p_full_set) // R3
		else $error("full flag not set after transfer");

	property p_full_clear;
		@(posedge pclk) disable iff (!presetn)
		$fell(flags_q.full) |-> $past(rd_data && arm_full_q);
	endproperty
	a_full_clear: assert property (p_full_clear) // R4
		else $error("full flag cleared without read sequence");

	property p_full_clear_done;
		@(posedge pclk) disable iff (!presetn)
		(s_data_read_armed and (!xfer_done)) |=> !flags_q.full;
	endproperty
	a_full_clear_done: assert property (p_full_clear_done) // R4
		else $error("full flag stayed after armed data read");

	property p_match_set;
		@(posedge pclk) disable iff (!presetn)
		(clk_en && xfer_done && rx_data == match_val_q && !wr_match)
		##1 clk_en |=> flags_q.match;
	endproperty
	a_match_set: assert property (p_match_set) // R5
		else $error("match flag not set on equal byte");

	property p_match_clear;
		@(posedge pclk) disable iff (!presetn)
		$fell(flags_q.match) |-> $past(!equal
			|| (wr_status && arm_match_q && pwdata[BIT_MATCH]));
	endproperty
	a_match_clear: assert property (p_match_clear) // R6
		else $error("match flag cleared without read then write");

	property p_match_arm;
		@(posedge pclk) disable iff (!presetn)
		(s_status_read and (flags_q.match && equal && !match_set_q))
		|=> arm_match_q;
	endproperty
	a_match_arm: assert property (p_match_arm) // R6
		else $error("status read did not arm match clear");

	property p_match_zero;
		@(posedge pclk) disable iff (!presetn)
		(pready_q && !pwrite && reg_hit(paddr, IDX_SERIAL_STATUS))
		|-> !(prdata_q[BIT_MATCH] && $past(!equal));
	endproperty
	a_match_zero: assert property (p_match_zero) // R7
		else $error("match read one while buffer differs");

	property p_match_keep;
		@(posedge pclk) disable iff (!presetn)
		(wr_status && !arm_match_q && equal && !match_set_q)
		|=> (flags_q.match == $past(flags_q.match));
	endproperty
	a_match_keep: assert property (p_match_keep) // R1
		else $error("match flag cleared by unarmed status write");

	// Stored flag must follow the compare, not only the read value
	property p_match_drop;
		@(posedge pclk) disable iff (!presetn)
		(clk_en && !equal) |=> !flags_q.match;
	endproperty
	a_match_drop: assert property (p_match_drop) // R7
		else $error("match flag kept while buffer differs");

	property p_reset_clear;
		@(posedge pclk) !presetn |-> (!flags_q.full && !flags_q.match);
	endproperty
	a_reset_clear: assert property (p_reset_clear) // R8
		else $error("flags not clear in reset");

endmodule

// [ssf_pkg.sv]
/*
 * Shared constants and types for the serial status-flag block.
 * Assumes a 32-bit APB master and a shift engine in the same clock domain.
 */
package ssf_pkg;
	// Bus widths
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned BYTE_W = 8;

	// Register indices; byte address is four times the index
	localparam logic [ADDR_W-1:0] IDX_SERIAL_STATUS = 8'h03;
	localparam logic [ADDR_W-1:0] IDX_MATCH_VALUE = 8'h04;
	localparam logic [ADDR_W-1:0] IDX_RX_DATA = 8'h05;
	localparam logic [ADDR_W-1:0] IDX_INT_STATUS = 8'h08;
	localparam logic [ADDR_W-1:0] IDX_INT_MASK = 8'h09;
	localparam int unsigned IDX_SHIFT = 2;

	// Status byte field positions
	localparam int unsigned BIT_FULL = 7;
	localparam int unsigned BIT_MATCH = 6;
	localparam logic [3:0] STATUS_LOW_ZERO = 4'h0;

	// Interrupt event bit positions
	localparam int unsigned EV_FULL = 0;
	localparam int unsigned EV_MATCH = 1;
	localparam int unsigned EV_W = 2;

	// Reset values
	localparam logic [BYTE_W-1:0] MATCH_RESET = 8'h00;
	localparam logic [BYTE_W-1:0] RXBUF_RESET = 8'h00;
	localparam logic [EV_W-1:0] EV_RESET = 2'h0;
	localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

	// Sticky flags, carried together
	typedef struct packed {
		logic full;
		logic match;
	} ssf_flags_s;

	localparam ssf_flags_s FLAGS_RESET = '{full: 1'b0, match: 1'b0};

	// Bus handshake states
	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ANSWER = 1'b1
	} ssf_bus_e;
endpackage

// [ssf_tb.sv]
/*
 * Self-checking bench for the serial status-flag block: APB master tasks,
 * a reference model of flags, buffer and interrupts, random receive bytes.
 * Assumes ssf_pkg and ssf_status are compiled first; clock enable is
 * dropped once for a single edge to prove that it freezes the block.
 */
`timescale 1ns/100ps

module testbench;
	import ssf_pkg::*;
	// Byte addresses, four times the register index
	localparam logic [7:0] A_ST = IDX_SERIAL_STATUS << IDX_SHIFT;
	localparam logic [7:0] A_MV = IDX_MATCH_VALUE << IDX_SHIFT;
	localparam logic [7:0] A_RX = IDX_RX_DATA << IDX_SHIFT;
	localparam logic [7:0] A_IS = IDX_INT_STATUS << IDX_SHIFT;
	localparam logic [7:0] A_IM = IDX_INT_MASK << IDX_SHIFT;
	// Clock, reset, bus and engine drive
	logic pclk = 1'b0;
	// Starts high so that the drop at time zero is a real falling edge
	logic presetn = 1'b1;
	logic clk_en = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic xfer_done = 1'b0;
	logic [7:0] rx_data = 8'h00;
	// Design outputs
	logic [31:0] prdata;
	logic pready, pslverr, irq;
	ssf_flags_s flags;
	// Model state; arm bits remember a status read with the flag set
	logic m_full = 0, m_match = 0, arm_f = 0, arm_m = 0;
	logic [7:0] m_buf = 0, m_mval = 0;
	logic [1:0] m_ist = 0, m_msk = 0;
	int miscompares = 0;
	int checks = 0;

	ssf_status dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .xfer_done(xfer_done), .rx_data(rx_data),
		.irq(irq), .flags(flags));

	// 200 MHz clock
	always #2.5 pclk = ~pclk;

	// Compare and count
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Single verdict point
	task close_out();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// One APB transfer, model update and read comparison
	task acc(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		logic bad;
		int n;
		bad = !(a inside {A_ST, A_MV, A_RX, A_IS, A_IM});
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		// Request held until pready is sampled high
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		// An answer on the last allowed edge is still a good answer
		if (pready !== 1'b1) begin
			miscompares++;
			close_out();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		chk(pslverr, bad);
		if (bad && !wr) begin
			chk(prdata, 32'h0);
		end else if (wr && !bad) begin
			// Status writes only touch the match flag
			case (a)
				A_ST: if (wd[6] && arm_m) begin
					m_match = 0;
					arm_m = 0;
				end
				A_MV: begin
					m_mval = wd[7:0];
					if (m_buf != m_mval) begin
						m_match = 0;
						arm_m = 0;
					end
				end
				A_IS: m_ist = m_ist & ~wd[1:0];
				A_IM: m_msk = wd[1:0];
				default: ;
			endcase
		end else if (!bad) begin
			case (a)
				A_ST: begin
					chk(prdata, {24'h0, m_full, m_match, 6'h0});
					if (m_full) arm_f = 1;
					if (m_match) arm_m = 1;
				end
				A_MV: chk(prdata, {24'h0, m_mval});
				A_RX: begin
					chk(prdata, {24'h0, m_buf});
					if (arm_f) begin
						m_full = 0;
						arm_f = 0;
					end
				end
				A_IS: chk(prdata, {30'h0, m_ist});
				default: chk(prdata, {30'h0, m_msk});
			endcase
		end
	endtask

	// Transfer-complete strobe from the shift engine
	task xfer(input logic [7:0] d);
		@(posedge pclk);
		xfer_done <= 1'b1;
		rx_data <= d;
		@(posedge pclk);
		xfer_done <= 1'b0;
		rx_data <= ~d;
		m_full = 1;
		arm_f = 0;
		// A new byte always drops a pending match clear
		arm_m = 0;
		m_buf = d;
		m_ist[0] = 1;
		m_match = (d == m_mval);
		if (m_match) m_ist[1] = 1;
		// Match lags full by one edge, irq by one more
		repeat (3) @(posedge pclk);
		chk(flags, {m_full, m_match});
		chk(irq, |(m_ist & m_msk));
	endtask

	// Main sequence
	initial begin
		logic [7:0] d;
		void'($urandom(15012));
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(flags, 0);
		acc(0, A_ST, 0);
		acc(1, A_ST, 32'hffff_ffff);
		acc(0, A_ST, 0);
		acc(0, 8'h3c, 0);
		acc(1, 8'h3c, 32'h1);
		// Enable low: a transfer strobe must leave no trace
		@(posedge pclk);
		clk_en <= 1'b0;
		xfer_done <= 1'b1;
		rx_data <= 8'h5a;
		@(posedge pclk);
		clk_en <= 1'b1;
		xfer_done <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(flags, {m_full, m_match});
		chk(irq, |(m_ist & m_msk));
		acc(0, A_RX, 0);
		for (int i = 0; i < 8; i++) begin
			d = $urandom;
			acc(1, A_IM, i);
			// Odd rounds miss the match value
			acc(1, A_MV, {24'h0, i[0] ? d ^ 8'h01 : d});
			xfer(d);
			acc(0, A_RX, 0);
			acc(1, A_ST, 32'h40);
			// Moving the match value away drops the flag
			if (i[1]) acc(1, A_MV, {24'h0, d + 8'h01});
			acc(0, A_ST, 0);
			acc(1, A_ST, 32'h40);
			acc(0, A_ST, 0);
			acc(0, A_RX, 0);
			acc(0, A_ST, 0);
			acc(0, A_IS, 0);
			chk(irq, |(m_ist & m_msk));
			acc(1, A_IS, 32'h3);
			repeat (2) @(posedge pclk);
			chk(irq, 1'b0);
		end
		close_out();
	end
endmodule
